// ===== src/ipd_pkg.sv
// shared constants and types for the initial position detector
package ipd_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int ACC_W = 24;
   localparam int MEAS_W = 8;
   localparam int RPM_W = 16;
   localparam int DIR_W = 3;
   localparam int NUM_DIRS = 6;
   localparam int NUM_SAL = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_US = 10;
   localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
   localparam int SETTLE_W = 12;

   // ----------------------------------------------------------------
   // speed thresholds for zero-crossing source
   // ----------------------------------------------------------------
   localparam logic [RPM_W-1:0] SPEED_UP_RPM = 16'h073F;
   localparam logic [RPM_W-1:0] SPEED_DOWN_RPM = 16'h070A;

   // ----------------------------------------------------------------
   // drive directions and masks
   // ----------------------------------------------------------------
   localparam logic [DIR_W-1:0] DIR_UV = 3'h0;
   localparam logic [DIR_W-1:0] DIR_VW = 3'h1;
   localparam logic [DIR_W-1:0] DIR_WU = 3'h2;
   localparam logic [DIR_W-1:0] DIR_VU = 3'h3;
   localparam logic [DIR_W-1:0] DIR_WV = 3'h4;
   localparam logic [DIR_W-1:0] DIR_UW = 3'h5;
   localparam logic [DIR_W-1:0] DIR_REV = 3'h3;
   localparam logic [NUM_DIRS-1:0] MASK_SAL = 6'h07;
   localparam logic [NUM_DIRS-1:0] MASK_ALL = 6'h3F;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_EDGE, ST_RUN, ST_SETTLE, ST_NEXT, ST_DONE, ST_FAIL
   } state_type;

   typedef enum logic [1:0] {MODE_SAL, MODE_REV, MODE_SAT} mode_type;

   typedef logic [NUM_DIRS-1:0][ACC_W-1:0] acc_arr_type;
   typedef logic [NUM_SAL-1:0][CNT_W-1:0] last_arr_type;

   typedef struct packed {
      logic [ACC_W-1:0] sal_thresh;
      logic [ACC_W-1:0] sat_thresh;
      logic [MEAS_W-1:0] max_meas;
   } cfg_type;

   typedef struct packed {
      logic success;
      logic fail;
      logic overflow;
      logic angle_valid;
      logic [DIR_W-1:0] angle_step;
   } result_type;
endpackage

// ===== src/pmsm_initial_position_detect.sv
// initial rotor position detector and zero-crossing source selector
`timescale 1ns/1ps
// Notes on behaviour
// - pulse U-V, V-W, W-U and time each
// - saliency gives 60 degree steps over 180
// - counter starts on pwm rising edge
// - shunt comparator event ends each measurement
// - accumulate per phase, stop at spread threshold
// - no spread after max rounds: saturation method
// - larger gap picks max or min phase
// - pulse selected phase reversed and time it
// - reversed versus mean of others judges saliency
// - lowest saturation count marks rotor direction
// - salient: forward and backward decide polarity
// - non-salient: six directions, minimum wins
// - saturation stops when spread passes threshold
// - at max rounds succeed above threshold, else fail
// - above 1855 rpm use back-emf comparator
// - comparator masked outside channel 0/2 window
// - return to converter at 1802 rpm
// - counter overflow stops drive, flags error
module pmsm_initial_position_detect
   import ipd_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic start,
   input wire cfg_type cfg,
   // timers and comparators
   input wire logic complementary_pwm_timer,
   input wire logic shunt_current_comparator,
   input wire logic backemf_comparator,
   input wire logic timer_array_unit_ch0,
   input wire logic timer_array_unit_ch2,
   input wire logic [RPM_W-1:0] speed_rpm,
   // inverter drive
   output logic drive_on,
   output logic [DIR_W-1:0] drive_dir,
   // detection status
   output logic busy,
   output result_type result,
   // zero-crossing path
   output logic use_comparator,
   output logic zero_cross
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [DIR_W-1:0] pick(input acc_arr_type a,
                                             input logic [NUM_DIRS-1:0] m,
                                             input logic want_max);
      logic [DIR_W-1:0] best;
      logic found;
      best = 3'h0;
      found = 1'b0;
      for (int i = 0; i < NUM_DIRS; i++) begin
         if (m[i]) begin
            if (!found || (want_max ? a[i] > a[best] : a[i] < a[best])) begin
               best = DIR_W'(i);
            end
            found = 1'b1;
         end
      end
      return best;
   endfunction

   // rotor angle in 60 degree steps for a drive direction
   function automatic logic [DIR_W-1:0] dir_angle(input logic [DIR_W-1:0] d);
      unique case (d)
         DIR_UV: dir_angle = 3'h0;
         DIR_UW: dir_angle = 3'h1;
         DIR_VW: dir_angle = 3'h2;
         DIR_VU: dir_angle = 3'h3;
         DIR_WU: dir_angle = 3'h4;
         DIR_WV: dir_angle = 3'h5;
         default: dir_angle = 3'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers and edge detectors
   // ----------------------------------------------------------------
   logic [1:0] shunt_sync;
   logic shunt_prev;
   logic [1:0] bemf_sync;
   logic bemf_prev;
   logic pwm_prev;
   logic shunt_hit;
   logic pwm_rise;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shunt_sync <= 2'h0;
         shunt_prev <= 1'b0;
         bemf_sync <= 2'h0;
         bemf_prev <= 1'b0;
         pwm_prev <= 1'b0;
      end else begin
         shunt_sync <= {shunt_sync[0], shunt_current_comparator};
         shunt_prev <= shunt_sync[1];
         bemf_sync <= {bemf_sync[0], backemf_comparator};
         bemf_prev <= bemf_sync[1];
         pwm_prev <= complementary_pwm_timer;
      end
   end

   assign shunt_hit = shunt_sync[1] & ~shunt_prev;
   assign pwm_rise = complementary_pwm_timer & ~pwm_prev;

   // ----------------------------------------------------------------
   // measurement state
   // ----------------------------------------------------------------
   state_type state;
   mode_type mode;
   logic [DIR_W-1:0] dir;
   logic [DIR_W-1:0] axis;
   logic [DIR_W-1:0] sel;
   logic sel_max;
   logic [NUM_DIRS-1:0] sat_mask;
   logic [CNT_W-1:0] cnt;
   logic [SETTLE_W-1:0] settle_cnt;
   logic [MEAS_W-1:0] rounds;
   acc_arr_type acc;
   last_arr_type last;

   // ----------------------------------------------------------------
   // decision arithmetic
   // ----------------------------------------------------------------
   logic [DIR_W-1:0] sal_mx;
   logic [DIR_W-1:0] sal_mn;
   logic [ACC_W+1:0] sal_med;
   logic [ACC_W+1:0] sal_hi_gap;
   logic [ACC_W+1:0] sal_lo_gap;
   logic [ACC_W-1:0] sal_spread;
   logic [DIR_W-1:0] sat_mx;
   logic [DIR_W-1:0] sat_mn;
   logic [ACC_W-1:0] sat_spread;
   logic [CNT_W+1:0] rev_twice;
   logic [CNT_W+1:0] rev_others;
   logic rev_ok;
   logic [MEAS_W-1:0] next_rounds;
   logic round_end;

   always_comb begin
      sal_mx = pick(acc, MASK_SAL, 1'b1);
      sal_mn = pick(acc, MASK_SAL, 1'b0);
      sal_med = (ACC_W+2)'(acc[0]) + (ACC_W+2)'(acc[1]) + (ACC_W+2)'(acc[2])
              - (ACC_W+2)'(acc[sal_mx]) - (ACC_W+2)'(acc[sal_mn]);
      sal_hi_gap = (ACC_W+2)'(acc[sal_mx]) - sal_med;
      sal_lo_gap = sal_med - (ACC_W+2)'(acc[sal_mn]);
      sal_spread = acc[sal_mx] - acc[sal_mn];
      sat_mx = pick(acc, sat_mask, 1'b1);
      sat_mn = pick(acc, sat_mask, 1'b0);
      sat_spread = acc[sat_mx] - acc[sat_mn];
      rev_twice = {1'b0, cnt, 1'b0};
      rev_others = (CNT_W+2)'(last[0]) + (CNT_W+2)'(last[1])
                 + (CNT_W+2)'(last[2]) - (CNT_W+2)'(last[sel[1:0]]);
      // reversed keeps the same side of the mean
      rev_ok = sel_max ? (rev_twice > rev_others) : (rev_twice < rev_others);
      next_rounds = rounds + 8'h01;
      round_end = (mode == MODE_SAL) ? (dir == DIR_WU)
                : (sat_mask == MASK_ALL) ? (dir == DIR_UW) : (dir != axis);
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         mode <= MODE_SAL;
         dir <= DIR_UV;
         axis <= DIR_UV;
         sel <= DIR_UV;
         sel_max <= 1'b0;
         sat_mask <= MASK_ALL;
         cnt <= '0;
         settle_cnt <= '0;
         rounds <= '0;
         acc <= '0;
         last <= '0;
      end else begin
         unique case (state)
            ST_IDLE, ST_DONE, ST_FAIL: begin
               if (start) begin
                  state <= ST_WAIT_EDGE;
                  mode <= MODE_SAL;
                  dir <= DIR_UV;
                  rounds <= '0;
                  acc <= '0;
               end
            end
            ST_WAIT_EDGE: begin
               cnt <= '0;
               if (pwm_rise) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (shunt_hit) begin
                  state <= ST_SETTLE;
                  settle_cnt <= '0;
                  if (mode != MODE_REV) begin
                     acc[dir] <= acc[dir] + ACC_W'(cnt);
                  end
                  if (mode == MODE_SAL) begin
                     last[dir[1:0]] <= cnt;
                  end
               end else if (cnt == {CNT_W{1'b1}}) begin
                  state <= ST_FAIL;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            ST_SETTLE: begin
               settle_cnt <= settle_cnt + 12'h001;
               if (settle_cnt == SETTLE_W'(SETTLE - 1)) begin
                  state <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               state <= ST_WAIT_EDGE;
               unique case (mode)
                  MODE_SAL: begin
                     if (!round_end) begin
                        dir <= dir + 3'h1;
                     end else if (sal_spread >= cfg.sal_thresh) begin
                        sel <= (sal_hi_gap > sal_lo_gap) ? sal_mx : sal_mn;
                        sel_max <= sal_hi_gap > sal_lo_gap;
                        axis <= sal_mn;
                        mode <= MODE_REV;
                        dir <= ((sal_hi_gap > sal_lo_gap) ? sal_mx : sal_mn) + DIR_REV;
                     end else if (next_rounds == cfg.max_meas) begin
                        mode <= MODE_SAT;
                        sat_mask <= MASK_ALL;
                        dir <= DIR_UV;
                        rounds <= '0;
                        acc <= '0;
                     end else begin
                        rounds <= next_rounds;
                        dir <= DIR_UV;
                     end
                  end
                  MODE_REV: begin
                     mode <= MODE_SAT;
                     rounds <= '0;
                     acc <= '0;
                     if (rev_ok) begin
                        sat_mask <= (6'h01 << axis) | (6'h01 << (axis + DIR_REV));
                        dir <= axis;
                     end else begin
                        sat_mask <= MASK_ALL;
                        dir <= DIR_UV;
                     end
                  end
                  MODE_SAT: begin
                     if (!round_end) begin
                        dir <= (sat_mask == MASK_ALL) ? dir + 3'h1 : axis + DIR_REV;
                     end else if (sat_spread > cfg.sat_thresh) begin
                        state <= ST_DONE;
                     end else if (next_rounds == cfg.max_meas) begin
                        state <= (sat_spread > cfg.sat_thresh) ? ST_DONE : ST_FAIL;
                     end else begin
                        rounds <= next_rounds;
                        dir <= (sat_mask == MASK_ALL) ? DIR_UV : axis;
                     end
                  end
                  default: begin
                     mode <= MODE_SAL;
                  end
               endcase
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // inverter drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drive_on <= 1'b0;
         drive_dir <= DIR_UV;
         busy <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE) && (state != ST_DONE) && (state != ST_FAIL);
         drive_dir <= dir;
         drive_on <= (state == ST_WAIT_EDGE)
                  || (state == ST_RUN && !shunt_hit && cnt != {CNT_W{1'b1}});
      end
   end

   // ----------------------------------------------------------------
   // result
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         result <= '0;
      end else if (state == ST_NEXT && mode == MODE_SAT && round_end
                   && sat_spread > cfg.sat_thresh) begin
         result.success <= 1'b1;
         result.angle_valid <= 1'b1;
         result.angle_step <= dir_angle(sat_mn);
      end else if (state == ST_NEXT && mode == MODE_SAT && round_end
                   && next_rounds == cfg.max_meas) begin
         result.fail <= 1'b1;
      end else if (state == ST_RUN && !shunt_hit && cnt == {CNT_W{1'b1}}) begin
         result.overflow <= 1'b1;
         result.fail <= 1'b1;
      end else if (start && !busy) begin
         result <= '0;
      end
   end

   // ----------------------------------------------------------------
   // zero-crossing source and window
   // ----------------------------------------------------------------
   logic window;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         use_comparator <= 1'b0;
         window <= 1'b0;
         zero_cross <= 1'b0;
      end else begin
         if (speed_rpm > SPEED_UP_RPM) begin
            use_comparator <= 1'b1;
         end else if (speed_rpm <= SPEED_DOWN_RPM) begin
            use_comparator <= 1'b0;
         end
         // window from channels 0 and 2
         if (timer_array_unit_ch0) begin
            window <= 1'b1;
         end else if (timer_array_unit_ch2) begin
            window <= 1'b0;
         end
         zero_cross <= use_comparator && window && (bemf_sync[1] != bemf_prev);
      end
   end

endmodule

// ===== bench/ipd_asserts.sv
// concurrent checks on the position detector ports
`timescale 1ns/1ps
module ipd_asserts
   import ipd_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // inputs watched
   input wire logic start,
   input wire logic shunt_current_comparator,
   input wire logic timer_array_unit_ch0,
   input wire logic timer_array_unit_ch2,
   input wire logic [RPM_W-1:0] speed_rpm,
   // outputs watched
   input wire logic drive_on,
   input wire logic [DIR_W-1:0] drive_dir,
   input wire logic busy,
   input wire result_type result,
   input wire logic use_comparator,
   input wire logic zero_cross
);
   logic [15:0] off_cnt;
   logic win;
   logic [4:0] win_hist;
   // ----------------------------------------------------------------
   // helper state: off time and timer window
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         off_cnt <= 16'hFFFF;
      end else if (drive_on) begin
         off_cnt <= 16'h0000;
      end else if (off_cnt != 16'hFFFF) begin
         off_cnt <= off_cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         win <= 1'b0;
         win_hist <= 5'h00;
      end else begin
         win <= timer_array_unit_ch0 | (win & ~timer_array_unit_ch2);
         win_hist <= {win_hist[3:0], win};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_accept;
      start && !busy;
   endsequence
   sequence s_first_pulse;
      ##2 busy && drive_on && drive_dir == DIR_UV;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_START: assert property (s_accept |-> s_first_pulse)
      else $error("first pulse not driven after start");
   AST_SETTLE: assert property ($rose(drive_on) |-> off_cnt >= SETTLE)
      else $error("pulse started before off time elapsed");
   AST_SHUNT_END: assert property (
      drive_on && $rose(shunt_current_comparator) |-> ##[1:5] !drive_on)
      else $error("drive not ended after shunt event");
   AST_DRIVE_BUSY: assert property (drive_on |-> busy)
      else $error("drive active outside detection");
   AST_OVF: assert property (
      $rose(result.overflow) |-> !drive_on && result.fail ##1 !busy)
      else $error("overflow did not stop drive");
   AST_FAIL_ANGLE: assert property (
      result.fail |-> !result.angle_valid && !result.success)
      else $error("angle shown on failure");
   AST_SUCCESS: assert property (result.success |-> result.angle_valid)
      else $error("success without angle");
   AST_CMP_UP: assert property (speed_rpm > SPEED_UP_RPM |=> use_comparator)
      else $error("comparator path not taken at high speed");
   AST_CMP_DOWN: assert property (speed_rpm <= SPEED_DOWN_RPM |=> !use_comparator)
      else $error("comparator path kept at low speed");
   AST_CMP_HOLD: assert property (
      speed_rpm > SPEED_DOWN_RPM && speed_rpm <= SPEED_UP_RPM |=> $stable(use_comparator))
      else $error("path changed inside hysteresis band");
   AST_ZC_WINDOW: assert property (
      zero_cross |-> win_hist != 5'h00 && $past(use_comparator))
      else $error("zero crossing outside window");
endmodule
bind pmsm_initial_position_detect ipd_asserts #(.SETTLE(SETTLE)) ipd_asserts_i (
   .clk, .reset_n, .start, .shunt_current_comparator, .timer_array_unit_ch0,
   .timer_array_unit_ch2, .speed_rpm, .drive_on, .drive_dir, .busy, .result,
   .use_comparator, .zero_cross
);

// ===== bench/motor_model.sv
// inverter, shunt comparator and motor stand-in
`timescale 1ns/1ps
module motor_model
   import ipd_pkg::*;
(
   // clock
   input wire logic clk,
   // inverter drive and per-direction rise times
   input wire logic drive_on,
   input wire logic [DIR_W-1:0] drive_dir,
   input wire logic [19:0] rise_delay [NUM_DIRS],
   // timer and comparator outputs
   output logic pwm,
   output logic shunt
);
   logic [3:0] phase = 4'h0;
   logic armed = 1'b0;
   logic [19:0] cnt = 20'h00000;
   assign pwm = phase[3];
   // current rises from the pwm edge
   always_ff @(posedge clk) begin
      phase <= phase + 4'h1;
      if (!drive_on) begin
         armed <= 1'b0;
         cnt <= 20'h00000;
         shunt <= 1'b0;
      end else if (!armed) begin
         armed <= (phase == 4'h7);
      end else if (cnt == rise_delay[drive_dir]) begin
         shunt <= 1'b1;
      end else begin
         cnt <= cnt + 20'h00001;
      end
   end
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the initial position detector
`timescale 1ns/1ps
module tb_top
   import ipd_pkg::*;
();
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic backemf_comparator = 1'b0;
   logic timer_array_unit_ch0 = 1'b0;
   logic timer_array_unit_ch2 = 1'b0;
   logic [RPM_W-1:0] speed_rpm = 16'h0000;
   cfg_type cfg = '0;
   logic complementary_pwm_timer, shunt_current_comparator, drive_on, busy;
   logic use_comparator, zero_cross;
   logic drive_q = 1'b0;
   logic [DIR_W-1:0] drive_dir;
   result_type result;
   logic [19:0] rise_delay [NUM_DIRS] = '{default: 20'h14};
   logic [DIR_W-1:0] dirs [$];
   int error_cnt = 0;
   int checked = 0;

   pmsm_initial_position_detect #(.SETTLE(4)) pmsm_initial_position_detect_i (
      .clk, .reset_n, .start, .cfg, .complementary_pwm_timer, .shunt_current_comparator,
      .backemf_comparator, .timer_array_unit_ch0, .timer_array_unit_ch2, .speed_rpm,
      .drive_on, .drive_dir, .busy, .result, .use_comparator, .zero_cross);
   motor_model motor_model_i (.clk, .drive_on, .drive_dir, .rise_delay,
      .pwm(complementary_pwm_timer), .shunt(shunt_current_comparator));

   initial begin
      forever #12.5 clk = ~clk;
   end
   // records the direction of every pulse
   always @(posedge clk) begin
      drive_q <= drive_on;
      if (drive_on && !drive_q) dirs.push_back(drive_dir);
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic run_det(input int limit);
      int n;
      n = 0;
      dirs.delete();
      start = 1'b1;
      cycles(1);
      start = 1'b0;
      cycles(2);
      chk(busy === 1'b1 && drive_on === 1'b1, "detection not started");
      while (busy === 1'b1 && n < limit) begin
         cycles(1);
         n++;
      end
      chk(busy === 1'b0 && drive_on === 1'b0, "detection did not end");
   endtask
   task automatic zc_try(input int want, input string msg);
      int n;
      n = 0;
      backemf_comparator = ~backemf_comparator;
      repeat (8) begin
         cycles(1);
         if (zero_cross === 1'b1) n++;
      end
      chk(n == want, msg);
   endtask
   task automatic pulse_ch(input logic open);
      timer_array_unit_ch0 = open;
      timer_array_unit_ch2 = ~open;
      cycles(1);
      timer_array_unit_ch0 = 1'b0;
      timer_array_unit_ch2 = 1'b0;
      cycles(1);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_salient;
      rise_delay = '{20'h1E, 20'h3C, 20'h14, 20'h05, 20'h3C, 20'h28};
      cfg = '{sal_thresh: 24'h000001, sat_thresh: 24'h000005, max_meas: 8'h04};
      run_det(5000);
      chk(dirs.size() == 6, "salient pulse count");
      chk(dirs[0] === DIR_UV && dirs[1] === DIR_VW && dirs[2] === DIR_WU, "order");
      chk(dirs[3] === DIR_WV, "reversed pulse not on wider-gap phase");
      chk((dirs[4] === DIR_WU && dirs[5] === DIR_UW) ||
          (dirs[4] === DIR_UW && dirs[5] === DIR_WU), "polarity pulses");
      chk(result.success === 1'b1 && result.angle_step === 3'h4, "salient angle");
      $display("salient test done");
   endtask
   task automatic test_weak;
      rise_delay = '{20'h1E, 20'h3C, 20'h14, 20'h05, 20'h0A, 20'h28};
      run_det(5000);
      chk(dirs.size() == 10 && dirs[3] === DIR_WV, "weak pulse count");
      for (int i = 0; i < NUM_DIRS; i++) begin
         chk(dirs[4 + i] === DIR_W'(i), "six direction order");
      end
      chk(result.success === 1'b1 && result.angle_step === 3'h3, "minimum direction");
      $display("weak saliency test done");
   endtask
   task automatic test_flat;
      rise_delay = '{default: 20'h14};
      cfg = '{sal_thresh: 24'h000001, sat_thresh: 24'h000000, max_meas: 8'h02};
      run_det(5000);
      chk(dirs.size() == 18, "flat pulse count");
      chk(dirs[6] === DIR_UV && dirs[9] === DIR_VU && dirs[11] === DIR_UW, "fallback");
      chk(result.fail === 1'b1 && result.success === 1'b0, "equal spread passed");
      chk(result.angle_valid === 1'b0, "angle shown on failure");
      $display("flat test done");
   endtask
   task automatic test_overflow;
      rise_delay = '{default: 20'hFFFFF};
      run_det(70000);
      chk(result.overflow === 1'b1 && result.fail === 1'b1, "overflow not flagged");
      chk(dirs.size() == 1 && result.angle_valid === 1'b0, "drive after overflow");
      $display("overflow test done");
   endtask
   task automatic test_zc;
      speed_rpm = SPEED_UP_RPM;
      cycles(3);
      chk(use_comparator === 1'b0, "switched at threshold");
      speed_rpm = SPEED_UP_RPM + 16'h0001;
      cycles(2);
      chk(use_comparator === 1'b1, "no switch above threshold");
      pulse_ch(1'b1);
      zc_try(1, "edge in window lost");
      pulse_ch(1'b0);
      zc_try(0, "edge outside window passed");
      speed_rpm = SPEED_DOWN_RPM + 16'h0001;
      cycles(3);
      chk(use_comparator === 1'b1, "left comparator early");
      pulse_ch(1'b1);
      speed_rpm = SPEED_DOWN_RPM;
      cycles(2);
      chk(use_comparator === 1'b0, "kept comparator at low speed");
      zc_try(0, "edge passed in converter mode");
      $display("zero-cross test done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #(90000 * 25);
      error_cnt++;
      $display("mismatch at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      cycles(3);
      reset_n = 1'b1;
      cycles(2);
      test_salient();
      test_weak();
      test_flat();
      test_zc();
      test_overflow();
      complete_run();
   end
endmodule
